// file: pkg/drive_regs_pkg.sv
// What this block does
// - Ready is reported only while the spindle is at speed, the servo is locked and the drive can read, write or seek.
// - Positioning done is set when a seek finishes and is meaningless while busy.
// - Positioning fault is set when a seek fault is seen and is meaningless while busy.
// - The track home flag is set whenever the carriage sits at cylinder zero and is meaningless while busy.
// - Busy stays asserted for the whole time a received command is being executed.
// - The unit unsafe flag is set on a write fault or a drive unsafe condition.
// - The order refused flag is set on a write while idle and not ready (sequence up, restore, fault reset clear it) or on an invalid command code.
// - Cylinder bits 10..8 sit in bits 2..0 of the upper byte with zeros above, bits 7..0 in the lower byte.
// - The address pair carries the target cylinder, the current cylinder or requested parameter data.
// - Bit 10 of the eleven-bit address value is the most significant and bit 0 the least.
// - Writes with selects 00, 01, 10 reach command, target upper and target lower; reads reach status, current upper and current lower.
// - A seek clears ready and sets busy during motion, then sets ready and positioning done.
// - A fault reset clears the positioning fault and unit unsafe flags.
// - A read identifier loads the identifier into the lower current byte and clears ready until sequence up or restore.
package drive_regs_pkg;

  localparam logic [1:0] sel_cmd_status = 2'h0;
  localparam logic [1:0] sel_upper = 2'h1;
  localparam logic [1:0] sel_lower = 2'h2;

  localparam int st_ready = 0;
  localparam int st_pos_done = 1;
  localparam int st_pos_fault = 2;
  localparam int st_home = 3;
  localparam int st_busy = 4;
  localparam int st_unsafe = 5;
  localparam int st_wr_inhibit = 6;
  localparam int st_refused = 7;

  localparam logic [7:0] cmd_seq_up = 8'h01;
  localparam logic [7:0] cmd_seq_down = 8'h02;
  localparam logic [7:0] cmd_restore = 8'h03;
  localparam logic [7:0] cmd_seek = 8'h04;
  localparam logic [7:0] cmd_fault_reset = 8'h05;
  localparam logic [7:0] cmd_read_id = 8'h10;
  localparam logic [7:0] cmd_read_bps = 8'h11;

  localparam logic [10:0] cyl_reset = 11'h000;
  localparam logic [7:0] status_reset = 8'h40;
  // Identifier value is arbitrary.
  localparam logic [7:0] drive_id_value = 8'h5a;
  localparam logic [10:0] bytes_per_sector = 11'h200;

  typedef struct packed {
    logic at_speed;
    logic servo_locked;
    logic can_operate;
    logic motion_done;
    logic motion_fault;
    logic spin_done;
    logic spin_fault;
    logic at_home;
    logic write_fault;
    logic unsafe;
  } mech_status_t;

  typedef struct packed {
    logic seek;
    logic restore;
    logic spin_up;
    logic spin_down;
  } mech_cmd_t;

  typedef enum logic [1:0] {
    idle_s = 2'b00,
    moving_s = 2'b01,
    spinning_s = 2'b11
  } exec_state_t;

endpackage

// file: design/addr_byte_split.sv
`timescale 1ns/1ns
module addr_byte_split (
  input wire logic [10:0] i_value,
  output logic [7:0] o_upper,
  output logic [7:0] o_lower
);
  always_comb
  begin
    o_upper = {5'h00, i_value[10:8]};
    o_lower = i_value[7:0];
  end
endmodule

// file: design/byte_lane_port.sv
`timescale 1ns/1ns
module byte_lane_port (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_unit_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_reg_select_high,
  input wire logic i_reg_select_low,
  input wire logic [7:0] i_host_byte_lines,
  input wire logic [7:0] i_read_data_sel0,
  input wire logic [7:0] i_read_data_sel1,
  input wire logic [7:0] i_read_data_sel2,
  output logic o_write_pulse,
  output logic [1:0] o_write_sel,
  output logic [7:0] o_write_data,
  output logic [7:0] o_host_byte_lines,
  output logic o_host_byte_lines_oe_n
);
  logic wr_prev;
  logic next_wr_prev;
  logic [7:0] next_out;
  logic next_oe_n;
  logic [1:0] sel;

  assign sel = {i_reg_select_high, i_reg_select_low};

  // A write is taken once, on the rising edge of the strobe with unit select.
  always_comb
  begin
    next_wr_prev = i_wr & i_unit_select;
    o_write_pulse = next_wr_prev & ~wr_prev & ~i_rd;
    o_write_sel = sel;
    o_write_data = i_host_byte_lines;
    next_oe_n = ~(i_unit_select & i_rd & ~i_wr);
    unique case (sel)
      drive_regs_pkg::sel_cmd_status: next_out = i_read_data_sel0;
      drive_regs_pkg::sel_upper: next_out = i_read_data_sel1;
      drive_regs_pkg::sel_lower: next_out = i_read_data_sel2;
      default: next_out = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_prev <= 1'b0;
      o_host_byte_lines <= 8'h00;
      o_host_byte_lines_oe_n <= 1'b1;
    end
    else
    begin
      wr_prev <= next_wr_prev;
      o_host_byte_lines <= next_out;
      o_host_byte_lines_oe_n <= next_oe_n;
    end
  end
endmodule

// file: design/drive_status_cylinder_regs.sv
`timescale 1ns/1ns
module drive_status_cylinder_regs (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_unit_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_reg_select_high,
  input wire logic i_reg_select_low,
  input wire logic [7:0] i_host_byte_lines,
  input wire drive_regs_pkg::mech_status_t i_mech,
  input wire logic [7:0] i_head_protect,
  input wire logic [2:0] i_head_sel,
  input wire logic [10:0] i_current_cyl,
  output logic [7:0] o_host_byte_lines,
  output logic o_host_byte_lines_oe_n,
  output drive_regs_pkg::mech_cmd_t o_mech_cmd,
  output logic [10:0] o_target_cyl,
  output logic [7:0] o_command
);
  logic wr_pulse;
  logic [1:0] wr_sel;
  logic [7:0] wr_data;
  logic [7:0] status;
  logic [7:0] cur_upper;
  logic [7:0] cur_lower;

  drive_regs_pkg::exec_state_t state, next_state;
  logic ready, next_ready;
  logic pos_done, next_pos_done;
  logic pos_fault, next_pos_fault;
  logic busy, next_busy;
  logic unsafe, next_unsafe;
  logic refused, next_refused;
  logic seq_up, next_seq_up;
  logic param_mode, next_param_mode;
  logic [10:0] param_value, next_param_value;
  logic [10:0] target, next_target;
  logic [7:0] command, next_command;
  drive_regs_pkg::mech_cmd_t next_mech_cmd;
  logic [10:0] shown_cyl;
  logic wr_inhibit;

  function automatic logic valid_code(input logic [7:0] code);
    valid_code = (code == drive_regs_pkg::cmd_seq_up) ||
      (code == drive_regs_pkg::cmd_seq_down) ||
      (code == drive_regs_pkg::cmd_restore) ||
      (code == drive_regs_pkg::cmd_seek) ||
      (code == drive_regs_pkg::cmd_fault_reset) ||
      (code == drive_regs_pkg::cmd_read_id) ||
      (code == drive_regs_pkg::cmd_read_bps);
  endfunction

  byte_lane_port u_port (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_unit_select(i_unit_select),
    .i_rd(i_rd),
    .i_wr(i_wr),
    .i_reg_select_high(i_reg_select_high),
    .i_reg_select_low(i_reg_select_low),
    .i_host_byte_lines(i_host_byte_lines),
    .i_read_data_sel0(status),
    .i_read_data_sel1(cur_upper),
    .i_read_data_sel2(cur_lower),
    .o_write_pulse(wr_pulse),
    .o_write_sel(wr_sel),
    .o_write_data(wr_data),
    .o_host_byte_lines(o_host_byte_lines),
    .o_host_byte_lines_oe_n(o_host_byte_lines_oe_n)
  );

  // Last requested parameter from a parameter command until sequence up or restore, else current cylinder.
  assign shown_cyl = param_mode ? param_value : i_current_cyl;

  addr_byte_split u_split (
    .i_value(shown_cyl),
    .o_upper(cur_upper),
    .o_lower(cur_lower)
  );

  assign wr_inhibit = ~seq_up | i_head_protect[i_head_sel];

  always_comb
  begin
    status = 8'h00;
    status[drive_regs_pkg::st_ready] = ready & i_mech.at_speed &
      i_mech.servo_locked & i_mech.can_operate;
    status[drive_regs_pkg::st_pos_done] = pos_done;
    status[drive_regs_pkg::st_pos_fault] = pos_fault;
    status[drive_regs_pkg::st_home] = i_mech.at_home;
    status[drive_regs_pkg::st_busy] = busy;
    status[drive_regs_pkg::st_unsafe] = unsafe;
    status[drive_regs_pkg::st_wr_inhibit] = wr_inhibit;
    status[drive_regs_pkg::st_refused] = refused;
  end

  always_comb
  begin
    next_state = state;
    next_ready = ready;
    next_pos_done = pos_done;
    next_pos_fault = pos_fault;
    next_busy = busy;
    next_unsafe = unsafe | i_mech.write_fault | i_mech.unsafe;
    next_refused = refused;
    next_seq_up = seq_up;
    next_param_mode = param_mode;
    next_param_value = param_value;
    next_target = target;
    next_command = command;
    next_mech_cmd = '0;
    unique case (state)
      drive_regs_pkg::idle_s:
      begin
        if (wr_pulse)
        begin
          if (!ready)
            next_refused = 1'b1;
          unique case (wr_sel)
            drive_regs_pkg::sel_upper:
              next_target = {wr_data[2:0], target[7:0]};
            drive_regs_pkg::sel_lower:
              next_target = {target[10:8], wr_data};
            default:
            begin
              next_command = wr_data;
              if (!valid_code(wr_data))
                next_refused = 1'b1;
              else if (wr_data == drive_regs_pkg::cmd_fault_reset)
              begin
                next_pos_fault = 1'b0;
                // A fault seen in the same cycle as the clear still sets.
                next_unsafe = i_mech.write_fault | i_mech.unsafe;
                next_refused = 1'b0;
              end
              else if (wr_data == drive_regs_pkg::cmd_read_id)
              begin
                next_param_mode = 1'b1;
                next_param_value = {3'h0, drive_regs_pkg::drive_id_value};
                next_ready = 1'b0;
              end
              else if (wr_data == drive_regs_pkg::cmd_read_bps)
              begin
                next_param_mode = 1'b1;
                next_param_value = drive_regs_pkg::bytes_per_sector;
                next_ready = 1'b0;
              end
              else if (wr_data == drive_regs_pkg::cmd_seek && ready)
              begin
                next_ready = 1'b0;
                next_busy = 1'b1;
                next_pos_done = 1'b0;
                next_mech_cmd.seek = 1'b1;
                next_state = drive_regs_pkg::moving_s;
              end
              else if (wr_data == drive_regs_pkg::cmd_seek)
                next_refused = 1'b1;
              else if (wr_data == drive_regs_pkg::cmd_seq_down)
              begin
                next_busy = 1'b1;
                next_ready = 1'b0;
                next_mech_cmd.spin_down = 1'b1;
                next_state = drive_regs_pkg::spinning_s;
              end
              else
              begin
                // Restore acts as sequence up when the drive is down.
                next_busy = 1'b1;
                next_ready = 1'b0;
                next_refused = 1'b0;
                next_param_mode = 1'b0;
                next_mech_cmd.restore = seq_up &
                  (wr_data == drive_regs_pkg::cmd_restore);
                next_mech_cmd.spin_up = ~next_mech_cmd.restore;
                next_state = seq_up &
                  (wr_data == drive_regs_pkg::cmd_restore) ?
                  drive_regs_pkg::moving_s : drive_regs_pkg::spinning_s;
              end
            end
          endcase
        end
      end
      drive_regs_pkg::moving_s:
      begin
        if (i_mech.motion_done | i_mech.motion_fault)
        begin
          next_busy = 1'b0;
          next_ready = 1'b1;
          next_pos_done = 1'b1;
          if (i_mech.motion_fault)
            next_pos_fault = 1'b1;
          next_state = drive_regs_pkg::idle_s;
        end
      end
      drive_regs_pkg::spinning_s:
      begin
        if (i_mech.spin_done | i_mech.spin_fault)
        begin
          next_busy = 1'b0;
          if (command == drive_regs_pkg::cmd_seq_down)
            next_seq_up = 1'b0;
          else if (i_mech.spin_fault)
          begin
            next_seq_up = 1'b0;
            next_unsafe = 1'b1;
          end
          else
          begin
            next_seq_up = 1'b1;
            next_ready = 1'b1;
            next_pos_done = 1'b1;
          end
          next_state = drive_regs_pkg::idle_s;
        end
      end
      default: next_state = drive_regs_pkg::idle_s;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= drive_regs_pkg::idle_s;
      ready <= 1'b0;
      pos_done <= 1'b0;
      pos_fault <= 1'b0;
      busy <= 1'b0;
      unsafe <= 1'b0;
      refused <= 1'b0;
      seq_up <= 1'b0;
      param_mode <= 1'b0;
      param_value <= drive_regs_pkg::cyl_reset;
      target <= drive_regs_pkg::cyl_reset;
      command <= 8'h00;
      o_mech_cmd <= '0;
      o_target_cyl <= drive_regs_pkg::cyl_reset;
      o_command <= 8'h00;
    end
    else
    begin
      state <= next_state;
      ready <= next_ready;
      pos_done <= next_pos_done;
      pos_fault <= next_pos_fault;
      busy <= next_busy;
      unsafe <= next_unsafe;
      refused <= next_refused;
      seq_up <= next_seq_up;
      param_mode <= next_param_mode;
      param_value <= next_param_value;
      target <= next_target;
      command <= next_command;
      o_mech_cmd <= next_mech_cmd;
      o_target_cyl <= next_target;
      o_command <= next_command;
    end
  end
endmodule

// file: dv/regs_monitor.sv
`timescale 1ns/1ns
module regs_monitor (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_unit_select,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_reg_select_high,
  input wire logic i_reg_select_low,
  input wire drive_regs_pkg::mech_status_t i_mech,
  input wire logic [7:0] o_host_byte_lines,
  input wire logic o_host_byte_lines_oe_n,
  input wire drive_regs_pkg::mech_cmd_t o_mech_cmd,
  input wire logic [10:0] o_target_cyl,
  input wire logic [7:0] o_command
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire rd_req = i_unit_select & i_rd & ~i_wr;
  wire wr_req = i_unit_select & i_wr & ~i_rd;
  wire [1:0] sel = {i_reg_select_high, i_reg_select_low};
  a_read_drives_bus: assert property (rd_req |=> !o_host_byte_lines_oe_n)
    else $error("bus not driven after a read");
  a_bus_released: assert property (
    !(i_unit_select && i_rd) |=> o_host_byte_lines_oe_n)
    else $error("bus still driven after read ended");
  a_drive_cause: assert property (
    !o_host_byte_lines_oe_n |-> $past(rd_req))
    else $error("bus driven without a read");
  a_upper_zeros: assert property (
    rd_req && sel == 2'h1 |=> o_host_byte_lines[7:3] == 5'h00)
    else $error("upper byte top bits not zero");
  a_cmd_single: assert property (o_mech_cmd != 4'h0 |=> o_mech_cmd == 4'h0)
    else $error("mechanism command longer than one cycle");
  a_cmd_onehot: assert property ($onehot0(o_mech_cmd))
    else $error("two mechanism commands at once");
  a_tgt_upper_src: assert property (
    $changed(o_target_cyl[10:8]) |-> $past(wr_req && sel == 2'h1))
    else $error("target upper changed without its write");
  a_tgt_lower_src: assert property (
    $changed(o_target_cyl[7:0]) |-> $past(wr_req && sel == 2'h2))
    else $error("target lower changed without its write");
  a_command_src: assert property (
    $changed(o_command) |-> $past(wr_req && sel[1] == sel[0]))
    else $error("command changed without a command write");
  a_ready_speed: assert property (
    rd_req && sel == 2'h0 && !i_mech.at_speed && !$past(i_mech.at_speed)
    |=> !o_host_byte_lines[0])
    else $error("ready shown while not at speed");
endmodule

// file: dv/ctl_model.sv
`timescale 1ns/1ns
module ctl_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_host_byte_lines,
  input wire logic i_host_byte_lines_oe_n,
  output logic o_unit_select,
  output logic o_rd,
  output logic o_wr,
  output logic o_reg_select_high,
  output logic o_reg_select_low,
  output logic [7:0] o_host_byte_lines
);
  initial
  begin
    o_unit_select = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    {o_reg_select_high, o_reg_select_low} = 2'h3;
    o_host_byte_lines = 8'h00;
  end
  // Released data lines show the inverse so stale values never match.
  task wr_reg(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_core_clk);
    o_unit_select <= 1'b1;
    o_wr <= 1'b1;
    {o_reg_select_high, o_reg_select_low} <= s;
    o_host_byte_lines <= d;
    @(posedge i_core_clk);
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_unit_select <= 1'b0;
    o_host_byte_lines <= ~d;
    @(posedge i_core_clk);
  endtask
  task rd_reg(input logic [1:0] s, output logic [7:0] d);
    @(posedge i_core_clk);
    o_unit_select <= 1'b1;
    o_rd <= 1'b1;
    {o_reg_select_high, o_reg_select_low} <= s;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    d = i_host_byte_lines_oe_n ? 8'hxx : i_host_byte_lines;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_unit_select <= 1'b0;
  endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ns
module tb;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic us, rd, wr, sh, sl;
  logic [7:0] din, dout, prot = 8'h04;
  logic oe_n;
  logic [2:0] hsel = 3'h2;
  logic [10:0] cur = 11'h6c5;
  logic [10:0] tgt;
  logic [7:0] cmd;
  drive_regs_pkg::mech_status_t mech = '0;
  drive_regs_pkg::mech_cmd_t mc;
  int err_total = 0;
  int n_checks = 0;
  int seeks = 0;
  int downs = 0;
  int ups = 0;
  int rsts = 0;
  always #50 i_core_clk = ~i_core_clk;
  ctl_model i_ctl (.i_core_clk, .i_host_byte_lines(dout),
    .i_host_byte_lines_oe_n(oe_n), .o_unit_select(us), .o_rd(rd),
    .o_wr(wr), .o_reg_select_high(sh), .o_reg_select_low(sl),
    .o_host_byte_lines(din));
  drive_status_cylinder_regs i_dut (.i_core_clk, .i_sys_rst,
    .i_unit_select(us), .i_rd(rd), .i_wr(wr), .i_reg_select_high(sh),
    .i_reg_select_low(sl), .i_host_byte_lines(din), .i_mech(mech),
    .i_head_protect(prot), .i_head_sel(hsel), .i_current_cyl(cur),
    .o_host_byte_lines(dout), .o_host_byte_lines_oe_n(oe_n),
    .o_mech_cmd(mc), .o_target_cyl(tgt), .o_command(cmd));
  always @(posedge i_core_clk)
  begin
    if (mc.seek === 1'b1)
      seeks++;
    if (mc.spin_down === 1'b1)
      downs++;
    if (mc.spin_up === 1'b1)
      ups++;
    if (mc.restore === 1'b1)
      rsts++;
  end
  task chk(input logic [10:0] got, input logic [10:0] exp,
    input logic [10:0] m);
    n_checks++;
    if ((got & m) !== (exp & m))
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rr(input logic [1:0] s, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    i_ctl.rd_reg(s, d);
    chk({3'h0, d}, {3'h0, e}, {3'h0, m});
  endtask
  task wc(input logic [7:0] c);
    i_ctl.wr_reg(2'h0, c);
  endtask
  // Bit index into the mechanism status word, bit 0 is unsafe.
  task pulse(input int b);
    @(posedge i_core_clk);
    mech[b] <= 1'b1;
    @(posedge i_core_clk);
    mech[b] <= 1'b0;
    repeat (2) @(posedge i_core_clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    err_total++;
    wrap_up;
  end
  initial
  begin
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rr(2'h0, 8'h40, 8'hff);
    mech[9:7] <= 3'h7;
    mech[2] <= 1'b1;
    wc(drive_regs_pkg::cmd_seq_up);
    rr(2'h0, 8'h10, 8'h11);
    pulse(4);
    rr(2'h0, 8'h49, 8'hd9);
    hsel <= 3'h1;
    rr(2'h0, 8'h01, 8'h41);
    mech[9] <= 1'b0;
    rr(2'h0, 8'h00, 8'h01);
    mech[9] <= 1'b1;
    $display("test status done");
    i_ctl.wr_reg(2'h1, 8'h05);
    i_ctl.wr_reg(2'h2, 8'ha3);
    chk(tgt, 11'h5a3, 11'h7ff);
    wc(drive_regs_pkg::cmd_seek);
    rr(2'h0, 8'h10, 8'h11);
    i_ctl.wr_reg(2'h2, 8'h00);
    chk(tgt, 11'h5a3, 11'h7ff);
    pulse(6);
    rr(2'h0, 8'h03, 8'h13);
    rr(2'h1, 8'h06, 8'hff);
    rr(2'h2, 8'hc5, 8'hff);
    rr(2'h0, 8'h03, 8'h13);
    $display("test seek done");
    mech[1] <= 1'b1;
    @(posedge i_core_clk);
    mech[1] <= 1'b0;
    rr(2'h0, 8'h20, 8'h20);
    wc(drive_regs_pkg::cmd_seek);
    pulse(5);
    pulse(6);
    rr(2'h0, 8'h04, 8'h14);
    wc(8'h7e);
    chk({3'h0, cmd}, 11'h07e, 11'h0ff);
    rr(2'h0, 8'h80, 8'h80);
    wc(drive_regs_pkg::cmd_fault_reset);
    rr(2'h0, 8'h00, 8'ha4);
    $display("test faults done");
    wc(drive_regs_pkg::cmd_read_id);
    rr(2'h0, 8'h00, 8'h11);
    rr(2'h2, drive_regs_pkg::drive_id_value, 8'hff);
    wc(drive_regs_pkg::cmd_read_bps);
    rr(2'h0, 8'h80, 8'h91);
    rr(2'h1, 8'h02, 8'hff);
    rr(2'h2, 8'h00, 8'hff);
    wc(drive_regs_pkg::cmd_restore);
    pulse(6);
    rr(2'h0, 8'h01, 8'h11);
    wc(drive_regs_pkg::cmd_seq_down);
    pulse(4);
    rr(2'h0, 8'h40, 8'h40);
    // A seek while the drive is down is refused and starts no motion.
    wc(drive_regs_pkg::cmd_seek);
    rr(2'h0, 8'h80, 8'h91);
    chk({3'h0, cmd}, 11'h004, 11'h0ff);
    // A failed spin up leaves the drive down and flags it unsafe.
    wc(drive_regs_pkg::cmd_seq_up);
    pulse(3);
    rr(2'h0, 8'h60, 8'hf1);
    chk(11'(seeks), 11'h002, 11'h7ff);
    chk(11'(downs), 11'h001, 11'h7ff);
    chk(11'(ups), 11'h002, 11'h7ff);
    chk(11'(rsts), 11'h001, 11'h7ff);
    $display("test parameters done");
    wrap_up;
  end
endmodule
bind drive_status_cylinder_regs regs_monitor i_mon (.i_core_clk,
  .i_sys_rst, .i_unit_select, .i_rd, .i_wr, .i_reg_select_high,
  .i_reg_select_low, .i_mech, .o_host_byte_lines,
  .o_host_byte_lines_oe_n, .o_mech_cmd, .o_target_cyl, .o_command);
